// *** core/bsc_consts.svh ***
// constants for the bit-test-skip and call decoder
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
`define BSC_BTSS_TOP 4'h7
`define BSC_CALL_TOP 3'h4
`define BSC_PHASE_LAST 2'h3
`define BSC_PHASE_FIRST 2'h0
`define BSC_PHASE_READ 2'h1
`define BSC_PHASE_PROC 2'h2
`define BSC_PC_RESET 13'h0000
`define BSC_PC_STEP 13'h0001
`define BSC_INSTR_NOP 14'h0000
`define BSC_PHASE_STEP 2'h1
`define BSC_DATA_BITS 8
`define BSC_LATCH_HI 4
`define BSC_LATCH_LO 3
`define BSC_OP_HI 13
`define BSC_SKIP_OP_LO 10
`define BSC_CALL_OP_LO 11
`define BSC_BIT_HI 9
`define BSC_BIT_LO 7
`define BSC_ADDR_HI 6
`define BSC_ADDR_LO 0
`define BSC_TARGET_HI 10
`define BSC_TARGET_LO 0
`endif

// *** core/bsc_core.sv ***
// executes bit-test-skip-if-set and subroutine call in four phases
//
// Functional notes
// - decode skip-if-set, skip when bit is one
// - taken skip discards next, runs a nop
// - bit clear: next executes, no write
// - decode call, immediate loads pc bits 10:0
// - call pushes pc plus one, two cycles
// - latch bits 4:3 fill pc bits 12:11
`timescale 1ns/100ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_core
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// fetched instruction, valid for the whole cycle
	input wire logic [13:0] i_instr,
	// register file read data, sampled at the end of the last phase
	input wire logic [7:0] i_rd_data,
	// program-counter high latch from the register file
	input wire logic [4:0] i_pc_high_latch,
	// register file read request
	output bsc_pkg::bsc_rd_s o_rd,
	// stack push of the return address
	output bsc_pkg::bsc_push_s o_stack_top,
	// program counter and phase state
	output logic [12:0] o_pc,
	output logic [1:0] o_phase,
	output logic o_flush,
	output logic o_reg_write,
	output logic o_flag_write
);
	// decoded fields of the effective instruction
	logic is_skip;
	logic is_call;
	logic [2:0] bit_idx;
	logic [6:0] addr;
	logic [10:0] target;
	logic [13:0] instr_eff;

	// sequencing state
	logic [1:0] phase;
	bsc_pkg::bsc_state_e state;
	logic call_flush;
	logic [12:0] pc;
	logic [12:0] next_pc;
	logic [12:0] ret_addr;

	// skip test lanes
	logic [7:0] bit_hit;
	logic take;
	genvar g;

	// a flushed cycle sees a nop so nothing decodes
	// this also keeps the discarded word from reading or pushing anything
	assign instr_eff = (state == bsc_pkg::ST_FLUSH) ? `BSC_INSTR_NOP : i_instr;

	// field split of the effective word
	// the decoder is pure wiring; every timing decision stays here
	bsc_decode u_dec
	(
		.i_instr(instr_eff),
		.o_is_skip(is_skip),
		.o_is_call(is_call),
		.o_bit(bit_idx),
		.o_addr(addr),
		.o_target(target)
	);

	// one lane per data bit: a lane passes its bit only when the index picks it
	// a flat and-or keeps the test path short, at the cost of eight small gates
	generate
		for (g = 0; g < `BSC_DATA_BITS; g++)
		begin : g_bit_lane
			assign bit_hit[g] = (bit_idx == 3'(g)) && i_rd_data[g];
		end
	endgenerate

	// skip taken only on a one
	// a zero lets the next word run in the usual single cycle
	assign take = is_skip && (|bit_hit);

	// return address is the call's own address plus one
	// taken from the counter before the call loads the target
	assign ret_addr = pc + `BSC_PC_STEP;

	// four phase counter
	// wraps by itself, so the first phase is its only reset value
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			phase <= `BSC_PHASE_FIRST;
		else
			phase <= phase + `BSC_PHASE_STEP;
	end

	// flow state: flushed cycle follows a taken skip or a call
	// an illegal code falls back to run instead of flushing forever
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state <= bsc_pkg::ST_RUN;
		else if (phase == `BSC_PHASE_LAST)
		begin
			case (state)
				bsc_pkg::ST_RUN:
					if (take || is_call)
						state <= bsc_pkg::ST_FLUSH;
				bsc_pkg::ST_FLUSH:
					state <= bsc_pkg::ST_RUN;
				default:
					state <= bsc_pkg::ST_RUN;
			endcase
		end
	end

	// the flush after a call keeps the target in the program counter
	// otherwise the flushed cycle would step past the subroutine entry
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			call_flush <= 1'b0;
		else if (phase == `BSC_PHASE_LAST)
			call_flush <= (state == bsc_pkg::ST_RUN) && is_call;
	end

	// next program counter: call target, hold after a call, else step
	// a call never decodes in the flushed cycle, the word there is a nop
	always_comb
	begin
		next_pc = pc + `BSC_PC_STEP;
		if (is_call)
			next_pc = {i_pc_high_latch[`BSC_LATCH_HI:`BSC_LATCH_LO], target};
		else if (call_flush)
			next_pc = pc;
	end

	// program counter moves only on the last phase
	// the other three phases leave it still
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pc <= `BSC_PC_RESET;
		else if (phase == `BSC_PHASE_LAST)
			pc <= next_pc;
	end

	// register read request in the first phase
	// the address goes out every cycle; only the request qualifies it
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rd <= '0;
		else
		begin
			o_rd.req <= is_skip && (phase == `BSC_PHASE_FIRST);
			o_rd.addr <= addr;
		end
	end

	// push return address during the first phase of the call
	// data is refreshed every clock, the pulse alone marks the push
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_stack_top <= '0;
		else
		begin
			o_stack_top.push <= is_call && (phase == `BSC_PHASE_FIRST);
			o_stack_top.data <= ret_addr;
		end
	end

	// no register write from either instruction, flushed cycles included
	// kept as a registered zero so the port stays a clean flop output
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_reg_write <= 1'b0;
		else
			o_reg_write <= 1'b0;
	end

	// status flags are never touched by a skip or a call
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_flag_write <= 1'b0;
		else
			o_flag_write <= 1'b0;
	end

	// registered program counter, one clock behind the internal one
	// shows which instruction the other outputs belong to
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pc <= `BSC_PC_RESET;
		else
			o_pc <= pc;
	end

	// registered phase, lined up with the other outputs
	// outside logic can tell which phase each output belongs to
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_phase <= `BSC_PHASE_FIRST;
		else
			o_phase <= phase;
	end

	// flush flag marks the discarded nop cycle
	// it lags the internal state by one clock like every other output
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_flush <= 1'b0;
		else
			o_flush <= (state == bsc_pkg::ST_FLUSH);
	end
endmodule // bsc_core
`default_nettype wire

// *** core/bsc_decode.sv ***
// opcode field decoder for skip and call instructions
`timescale 1ns/100ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_decode
(
	// instruction word
	input wire logic [13:0] i_instr,
	// decoded fields
	output logic o_is_skip,
	output logic o_is_call,
	output logic [2:0] o_bit,
	output logic [6:0] o_addr,
	output logic [10:0] o_target
);
	// pattern match on the upper bits
	assign o_is_skip = (i_instr[`BSC_OP_HI:`BSC_SKIP_OP_LO] == `BSC_BTSS_TOP);
	assign o_is_call = (i_instr[`BSC_OP_HI:`BSC_CALL_OP_LO] == `BSC_CALL_TOP);
	assign o_bit = i_instr[`BSC_BIT_HI:`BSC_BIT_LO];
	assign o_addr = i_instr[`BSC_ADDR_HI:`BSC_ADDR_LO];
	assign o_target = i_instr[`BSC_TARGET_HI:`BSC_TARGET_LO];
endmodule // bsc_decode
`default_nettype wire

// *** core/bsc_pkg.sv ***
// types for the bit-test-skip and call decoder
`default_nettype none
package bsc_pkg;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_FLUSH
	} bsc_state_e;
	// register file read request
	typedef struct packed {
		logic req;
		logic [6:0] addr;
	} bsc_rd_s;
	// stack push request
	typedef struct packed {
		logic push;
		logic [12:0] data;
	} bsc_push_s;
endpackage
`default_nettype wire

// *** testbench/bsc_checker.sv ***
// checker for the skip and call decoder
`timescale 1ns/100ps
`default_nettype none
module bsc_checker
(
	// watched ports
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [13:0] i_instr,
	input wire logic [4:0] i_pc_high_latch,
	input wire bsc_pkg::bsc_rd_s o_rd,
	input wire bsc_pkg::bsc_push_s o_stack_top,
	input wire logic [12:0] o_pc,
	input wire logic o_flush,
	input wire logic o_reg_write,
	input wire logic o_flag_write
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_no_reg_write: assert property (!o_reg_write) else $error("reg write");
	a_no_flag_write: assert property (!o_flag_write) else $error("flag write");
	a_push_pulse: assert property (o_stack_top.push |=> !o_stack_top.push) else $error("push");
	a_push_data: assert property (o_stack_top.push |-> o_stack_top.data == o_pc + 13'h0001) else $error("ret");
	a_call_target: assert property (o_stack_top.push |-> ##4
		o_pc == {$past(i_pc_high_latch[4:3], 4), $past(i_instr[10:0], 4)}) else $error("target");
	a_call_flush: assert property (o_stack_top.push |-> ##4 o_flush) else $error("call flush");
	a_flush_len: assert property ($rose(o_flush) |-> o_flush[*4] ##1 !o_flush) else $error("flush");
	a_read_addr: assert property (o_rd.req |-> o_rd.addr == i_instr[6:0]) else $error("addr");
	c_push: cover property (o_stack_top.push);
	c_flush: cover property ($rose(o_flush));
	c_read: cover property (o_rd.req);
endmodule // bsc_checker
bind bsc_core bsc_checker chk_i (.*);
`default_nettype wire

// *** testbench/bsc_core_tb.sv ***
// testbench for the skip and call decoder
`timescale 1ns/100ps
`default_nettype none
module bsc_core_tb;
	logic i_clk = 0, i_rst_n = 0;
	logic [13:0] i_instr = 14'h0000;
	logic [7:0] i_rd_data = 8'h00;
	logic [4:0] i_pc_high_latch = 5'h18;
	bsc_pkg::bsc_rd_s o_rd;
	bsc_pkg::bsc_push_s o_stack_top;
	logic [12:0] o_pc;
	logic [1:0] o_phase;
	logic o_flush, o_reg_write, o_flag_write;
	integer bad_count = 0, tests_run = 0;
	bsc_core DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr(i_instr), .i_rd_data(i_rd_data),
		.i_pc_high_latch(i_pc_high_latch), .o_rd(o_rd), .o_stack_top(o_stack_top), .o_pc(o_pc),
		.o_phase(o_phase), .o_flush(o_flush), .o_reg_write(o_reg_write), .o_flag_write(o_flag_write));
	// clock
	initial forever #20 i_clk = ~i_clk;
	task chk(input logic [12:0] s, input logic [12:0] e, input string n);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task summarize;
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// reset realigns the phases before every scenario
	task rst(input logic [13:0] w);
		@(negedge i_clk) i_rst_n = 0;
		i_instr = w;
		repeat (10) @(negedge i_clk);
		i_rst_n = 1;
	endtask
	task t_call;
		integer i;
		rst(14'h27FF);
		for (i = 0; i < 12 && o_stack_top.push !== 1'b1; i++) @(negedge i_clk);
		chk({12'h000, o_stack_top.push}, 13'h0001, "push");
		chk(o_stack_top.data, 13'h0001, "ret");
		chk({11'h000, o_phase}, 13'h0000, "phase");
		for (i = 0; i < 12 && o_flush !== 1'b1; i++) @(negedge i_clk);
		chk(o_pc, 13'h1FFF, "pc");
		chk({11'h000, o_reg_write, o_flag_write}, 13'h0000, "wr");
		for (i = 0; i < 12 && o_stack_top.push !== 1'b1; i++) @(negedge i_clk);
		chk({12'h000, o_flush}, 13'h0000, "flush end");
		chk(o_pc, 13'h1FFF, "pc held");
		chk(o_stack_top.data, 13'h0000, "ret wrap");
	endtask
	task t_skip(input logic [7:0] d, input logic e);
		integer i;
		logic f;
		f = 0;
		i_rd_data = d;
		rst(14'h1FFF);
		for (i = 0; i < 12 && o_rd.req !== 1'b1; i++) @(negedge i_clk);
		chk({12'h000, o_rd.req}, 13'h0001, "req");
		chk({6'h00, o_rd.addr}, 13'h007F, "addr");
		for (i = 0; i < 12; i++)
		begin
			@(negedge i_clk);
			f = f | (o_flush === 1'b1);
		end
		chk({12'h000, f}, {12'h000, e}, "skip");
		chk(o_pc, 13'h0003, "pc step");
	endtask
	initial
	begin
		t_call;
		t_skip(8'h80, 1'b1);
		t_skip(8'h7F, 1'b0);
		summarize;
	end
	// watchdog
	initial
	begin
		#100000;
		bad_count++;
		summarize;
	end
endmodule // bsc_core_tb
`default_nettype wire
